// ===== sync_coast_pkg.sv
/*
 * Constants for the sync, coast and output format control register bank.
 * Assumes a 2-wire serial front end that turns bus transactions into
 * byte-wide register write strobes and read addresses on the core clock.
 */
package sync_coast_pkg;
	localparam logic [7:0] ADDR_DIV_HIGH = 8'h01;
	localparam logic [7:0] ADDR_DIV_LOW = 8'h02;
	localparam logic [7:0] ADDR_POL_SOURCE = 8'h0f;
	localparam logic [7:0] ADDR_SEP_THRESH = 8'h13;
	localparam logic [7:0] ADDR_POL_OVERRIDE = 8'h14;
	localparam logic [7:0] ADDR_POL_STATUS = 8'h15;
	localparam logic [7:0] ADDR_GREEN_SLICER = 8'h16;
	localparam logic [7:0] ADDR_COAST_LEAD = 8'h17;
	localparam logic [7:0] ADDR_COAST_TRAIL = 8'h18;
	localparam logic [7:0] ADDR_TEST_KEEP = 8'h19;
	localparam logic [7:0] ADDR_TEST_A = 8'h1a;
	localparam logic [7:0] ADDR_TEST_B = 8'h1b;
	localparam logic [7:0] ADDR_FORMAT = 8'h1c;
	localparam logic [7:0] ADDR_RSVD_FIRST = 8'h1d;
	localparam logic [7:0] ADDR_RSVD_LAST = 8'h1f;

	localparam logic [7:0] RST_SEP_THRESH = 8'h20;
	localparam logic [7:0] RST_POL_OVERRIDE = 8'h10;
	localparam logic [7:0] RST_GREEN_SLICER = 8'hb8;
	localparam logic [7:0] RST_COAST_LEAD = 8'h00;
	localparam logic [7:0] RST_COAST_TRAIL = 8'h00;
	localparam logic [7:0] RST_TEST_KEEP = 8'h00;
	localparam logic [7:0] RST_TEST_A = 8'hff;
	localparam logic [7:0] RST_TEST_B = 8'h00;
	localparam logic [7:0] RST_FORMAT = 8'h07;
	localparam logic [7:0] RST_POL_SOURCE = 8'h00;
	localparam logic [7:0] RST_DIV_HIGH = 8'h69;
	localparam logic [7:0] RST_DIV_LOW = 8'hd0;
	localparam logic [7:0] RSVD_READ_VALUE = 8'h00;

	localparam int BIT_SCAN_EN = 2;
	localparam int BIT_COAST_OVR = 1;
	localparam int BIT_HSYNC_OVR = 0;
	localparam int BIT_SRC_HSYNC_POL = 7;
	localparam int BIT_SRC_COAST_POL = 6;
	localparam int BIT_STAT_HSYNC = 7;
	localparam int BIT_STAT_VSYNC = 6;
	localparam int BIT_STAT_COAST = 5;
	localparam int BIT_FORMAT_444 = 0;
	localparam int SLICER_LSB = 3;
	localparam int SLICER_W = 5;
	localparam int DIV_W = 12;
	localparam int DIV_LOW_LSB = 4;
endpackage

// ===== sync_coast_format_control_regs.sv
/*
 * Control register bank for sync separation, coast, polarity and output
 * format, plus the pixel divider shadow/load logic.
 * Assumes the serial front end delivers one-cycle write strobes with
 * address and data, and samples read data two cycles after raising rd_addr.
 * Detected polarity levels come from pins and are synchronised here.
 */
`timescale 1ns/100ps
module sync_coast_format_control_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register access from the serial front end
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// Detected polarities from the sync processor (asynchronous)
	input wire logic hsync_pol_detected,
	input wire logic coast_pol_detected,
	input wire logic vsync_out_active_high,
	// Settings to the sync, coast and output logic
	output logic [7:0] sep_threshold,
	output logic scan_enable,
	output logic hsync_pol_used,
	output logic coast_pol_used,
	output logic [sync_coast_pkg::SLICER_W-1:0] slicer_threshold,
	output logic [7:0] coast_lead_count,
	output logic [7:0] coast_trail_count,
	output logic format_444,
	output logic [sync_coast_pkg::DIV_W:0] pixel_divide_ratio,
	output logic pixel_divider_load
);
	import sync_coast_pkg::*;

	typedef struct packed {
		logic [7:0] sep_thresh;
		logic [7:0] pol_override;
		logic [7:0] green_slicer;
		logic [7:0] coast_lead;
		logic [7:0] coast_trail;
		logic [7:0] test_keep;
		logic [7:0] test_a;
		logic [7:0] test_b;
		logic [7:0] format;
		logic [7:0] pol_source;
		logic [7:0] div_high;
		logic [7:0] div_low;
		logic [DIV_W-1:0] pixel_divider_value;
		logic [DIV_W:0] div_ratio;
		logic div_load;
		logic [2:0] hs_sync;
		logic [2:0] cs_sync;
		logic [2:0] vs_sync;
		logic hs_pol;
		logic cs_pol;
		logic vs_pol;
		logic [7:0] rd_data;
		logic hs_used;
		logic cs_used;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [7:0] status_byte;

	always_comb begin
		s_d = s_q;
		s_d.div_load = 1'b0;
		// Three-stage capture; a level counts once the last two stages agree
		s_d.hs_sync = {s_q.hs_sync[1:0], hsync_pol_detected};
		s_d.cs_sync = {s_q.cs_sync[1:0], coast_pol_detected};
		s_d.vs_sync = {s_q.vs_sync[1:0], vsync_out_active_high};
		if (s_q.hs_sync[2] == s_q.hs_sync[1]) begin
			s_d.hs_pol = s_q.hs_sync[2];
		end
		if (s_q.cs_sync[2] == s_q.cs_sync[1]) begin
			s_d.cs_pol = s_q.cs_sync[2];
		end
		if (s_q.vs_sync[2] == s_q.vs_sync[1]) begin
			s_d.vs_pol = s_q.vs_sync[2];
		end

		if (wr_en) begin
			unique case (wr_addr)
				ADDR_DIV_HIGH: begin
					// Held pending until the low half is written
					s_d.div_high = wr_data;
				end
				ADDR_DIV_LOW: begin
					s_d.div_low = wr_data;
					s_d.pixel_divider_value = {s_q.div_high, wr_data[7:DIV_LOW_LSB]};
					s_d.div_load = 1'b1;
				end
				ADDR_POL_SOURCE: begin
					s_d.pol_source = wr_data;
				end
				ADDR_SEP_THRESH: begin
					s_d.sep_thresh = wr_data;
				end
				ADDR_POL_OVERRIDE: begin
					s_d.pol_override = wr_data;
				end
				ADDR_GREEN_SLICER: begin
					s_d.green_slicer = wr_data;
				end
				ADDR_COAST_LEAD: begin
					s_d.coast_lead = wr_data;
				end
				ADDR_COAST_TRAIL: begin
					s_d.coast_trail = wr_data;
				end
				ADDR_TEST_KEEP: begin
					s_d.test_keep = wr_data;
				end
				ADDR_TEST_A: begin
					s_d.test_a = wr_data;
				end
				ADDR_TEST_B: begin
					s_d.test_b = wr_data;
				end
				ADDR_FORMAT: begin
					s_d.format = wr_data;
				end
				default: begin
					// Status, reserved and unmapped locations keep no state
				end
			endcase
		end

		// Ratio is registered so the output comes straight from a flop; extra bit keeps 4095+1
		s_d.div_ratio = {1'b0, s_d.pixel_divider_value} + 13'h001;

		// Override picks the host's polarity, else the detected one
		s_d.hs_used = s_q.pol_override[BIT_HSYNC_OVR] ? s_q.pol_source[BIT_SRC_HSYNC_POL] : s_q.hs_pol;
		s_d.cs_used = s_q.pol_override[BIT_COAST_OVR] ? s_q.pol_source[BIT_SRC_COAST_POL] : s_q.cs_pol;

		status_byte = 8'h00;
		status_byte[BIT_STAT_HSYNC] = s_q.hs_pol;
		status_byte[BIT_STAT_VSYNC] = ~s_q.vs_pol;
		status_byte[BIT_STAT_COAST] = s_q.cs_pol;

		unique case (rd_addr)
			ADDR_DIV_HIGH: s_d.rd_data = s_q.div_high;
			ADDR_DIV_LOW: s_d.rd_data = s_q.div_low;
			ADDR_POL_SOURCE: s_d.rd_data = s_q.pol_source;
			ADDR_SEP_THRESH: s_d.rd_data = s_q.sep_thresh;
			ADDR_POL_OVERRIDE: s_d.rd_data = s_q.pol_override;
			ADDR_POL_STATUS: s_d.rd_data = status_byte;
			ADDR_GREEN_SLICER: s_d.rd_data = s_q.green_slicer;
			ADDR_COAST_LEAD: s_d.rd_data = s_q.coast_lead;
			ADDR_COAST_TRAIL: s_d.rd_data = s_q.coast_trail;
			ADDR_TEST_KEEP: s_d.rd_data = s_q.test_keep;
			ADDR_TEST_A: s_d.rd_data = s_q.test_a;
			ADDR_TEST_B: s_d.rd_data = s_q.test_b;
			ADDR_FORMAT: s_d.rd_data = s_q.format;
			default: s_d.rd_data = RSVD_READ_VALUE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.sep_thresh <= RST_SEP_THRESH;
			s_q.pol_override <= RST_POL_OVERRIDE;
			s_q.green_slicer <= RST_GREEN_SLICER;
			s_q.coast_lead <= RST_COAST_LEAD;
			s_q.coast_trail <= RST_COAST_TRAIL;
			s_q.test_keep <= RST_TEST_KEEP;
			s_q.test_a <= RST_TEST_A;
			s_q.test_b <= RST_TEST_B;
			s_q.format <= RST_FORMAT;
			s_q.pol_source <= RST_POL_SOURCE;
			s_q.div_high <= RST_DIV_HIGH;
			s_q.div_low <= RST_DIV_LOW;
			s_q.pixel_divider_value <= {RST_DIV_HIGH, RST_DIV_LOW[7:DIV_LOW_LSB]};
			s_q.div_ratio <= {1'b0, RST_DIV_HIGH, RST_DIV_LOW[7:DIV_LOW_LSB]} + 13'h001;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rd_data;
	assign sep_threshold = s_q.sep_thresh;
	assign scan_enable = s_q.pol_override[BIT_SCAN_EN];
	assign hsync_pol_used = s_q.hs_used;
	assign coast_pol_used = s_q.cs_used;
	assign slicer_threshold = s_q.green_slicer[SLICER_LSB +: SLICER_W];
	assign coast_lead_count = s_q.coast_lead;
	assign coast_trail_count = s_q.coast_trail;
	assign format_444 = s_q.format[BIT_FORMAT_444];
	assign pixel_divide_ratio = s_q.div_ratio;
	assign pixel_divider_load = s_q.div_load;
endmodule

// ===== sync_coast_regs_chk.sv
/* Port assertions for the sync/coast register bank.
 * Bound to the bank from the testbench top; one clock domain. */
`timescale 1ns/100ps
module sync_coast_regs_chk import sync_coast_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register access
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Settings
	input wire logic [7:0] sep_threshold,
	input wire logic scan_enable,
	input wire logic [SLICER_W-1:0] slicer_threshold,
	input wire logic [7:0] coast_lead_count,
	input wire logic [7:0] coast_trail_count,
	input wire logic format_444,
	input wire logic [DIV_W:0] pixel_divide_ratio,
	input wire logic pixel_divider_load
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire low_wr = wr_en && wr_addr == ADDR_DIV_LOW;
	a_load_on_low: assert property (low_wr |=> pixel_divider_load) else $error("no load after low write");
	a_load_only_low: assert property (!low_wr |=> !pixel_divider_load) else $error("stray load");
	a_ratio_held: assert property (!pixel_divider_load |-> $stable(pixel_divide_ratio)) else $error("ratio moved");
	a_sep_write: assert property (wr_en && wr_addr == ADDR_SEP_THRESH |=> sep_threshold == $past(wr_data))
		else $error("threshold wrong");
	a_sep_kept: assert property (!(wr_en && wr_addr == ADDR_SEP_THRESH) |=> $stable(sep_threshold))
		else $error("threshold changed");
	a_scan_write: assert property (wr_en && wr_addr == ADDR_POL_OVERRIDE |=> scan_enable == $past(wr_data[BIT_SCAN_EN]))
		else $error("scan wrong");
	a_slicer_write: assert property (wr_en && wr_addr == ADDR_GREEN_SLICER |=> slicer_threshold == $past(wr_data[7:3]))
		else $error("slicer wrong");
	a_lead_write: assert property (wr_en && wr_addr == ADDR_COAST_LEAD |=> coast_lead_count == $past(wr_data))
		else $error("lead wrong");
	a_trail_write: assert property (wr_en && wr_addr == ADDR_COAST_TRAIL |=> coast_trail_count == $past(wr_data))
		else $error("trail wrong");
	a_format_write: assert property (wr_en && wr_addr == ADDR_FORMAT |=> format_444 == $past(wr_data[0]))
		else $error("format wrong");
	a_rsvd_read: assert property (rd_addr >= ADDR_RSVD_FIRST && rd_addr <= ADDR_RSVD_LAST |=> rd_data == RSVD_READ_VALUE)
		else $error("reserved read");
endmodule

// ===== host_bus_model.sv
/* Host side of the register access port: byte writes and reads.
 * Assumes the bank samples on the rising clk edge. */
`timescale 1ns/100ps
module host_bus_model import sync_coast_pkg::*; (
	input wire logic clk,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end
	// Released lines show the inverse so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_addr <= a;
		repeat (2) @(posedge clk);
		d = rd_data;
	endtask
	task automatic init();
		wr(ADDR_SEP_THRESH, 8'h40);
		wr(ADDR_POL_OVERRIDE, 8'h10);
		wr(ADDR_TEST_A, 8'h41);
		wr(ADDR_TEST_B, 8'h10);
		wr(ADDR_FORMAT, 8'h6f);
	endtask
endmodule

// ===== test_sync_coast_format_control_regs.sv
/* Self-checking bench for the register bank; host model drives the access port.
 * Polarity pins are driven here as plain levels. */
`timescale 1ns/100ps
module test_sync_coast_format_control_regs;
	import sync_coast_pkg::*;
	logic clk = 1'b0;
	logic resetn, hs_pin, co_pin, vs_pin, wr_en, scan_enable, hs_used, co_used, format_444, ld;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, sep, lead, trail, v;
	logic [SLICER_W-1:0] slicer;
	logic [DIV_W:0] ratio;
	int fail_count = 0;
	int cmp_count = 0;
	always #12.5 clk = ~clk;
	sync_coast_format_control_regs u_dut (.clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .hsync_pol_detected(hs_pin),
		.coast_pol_detected(co_pin), .vsync_out_active_high(vs_pin), .sep_threshold(sep),
		.scan_enable(scan_enable), .hsync_pol_used(hs_used), .coast_pol_used(co_used),
		.slicer_threshold(slicer), .coast_lead_count(lead), .coast_trail_count(trail),
		.format_444(format_444), .pixel_divide_ratio(ratio), .pixel_divider_load(ld));
	host_bus_model u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data));
	function automatic void chk(string n, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (e !== s) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endfunction
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_reset();
		u_host.rd(ADDR_SEP_THRESH, v);
		chk("sep", 16'h20, v);
		chk("slicer", 16'h17, slicer);
		chk("coast", 16'h0, {trail, lead});
		chk("fmt", 16'h1, format_444);
		chk("ratio", 16'd1694, ratio);
	endtask
	task automatic t_regs();
		logic [7:0] ra [6] = '{ADDR_SEP_THRESH, ADDR_GREEN_SLICER, ADDR_COAST_LEAD, ADDR_COAST_TRAIL, ADDR_TEST_A, ADDR_FORMAT};
		logic [7:0] rv [6] = '{8'ha5, 8'hc8, 8'hff, 8'h01, 8'h41, 8'h6e};
		for (int i = 0; i < 6; i++) u_host.wr(ra[i], rv[i]);
		for (int i = 0; i < 6; i++) begin
			u_host.rd(ra[i], v);
			chk("readback", rv[i], v);
		end
		chk("outs", 16'ha519, {sep, 3'h0, slicer});
		chk("coast", 16'h01ff, {trail, lead});
		chk("fmt422", 16'h0, format_444);
	endtask
	task automatic t_pol();
		hs_pin <= 1'b0;
		co_pin <= 1'b1;
		vs_pin <= 1'b1;
		u_host.wr(ADDR_POL_SOURCE, 8'h80);
		u_host.wr(ADDR_POL_OVERRIDE, 8'h17);
		repeat (6) @(posedge clk);
		chk("ovr", 16'h6, {scan_enable, hs_used, co_used});
		u_host.wr(ADDR_POL_OVERRIDE, 8'h10);
		repeat (6) @(posedge clk);
		chk("auto", 16'h1, {scan_enable, hs_used, co_used});
		u_host.rd(ADDR_POL_STATUS, v);
		chk("stat", 16'h20, v);
		hs_pin <= 1'b1;
		co_pin <= 1'b0;
		vs_pin <= 1'b0;
		repeat (8) @(posedge clk);
		u_host.rd(ADDR_POL_STATUS, v);
		chk("stat", 16'hc0, v);
	endtask
	task automatic t_rsvd();
		u_host.wr(ADDR_POL_STATUS, 8'h00);
		for (int i = 0; i < 3; i++) begin
			u_host.wr(ADDR_RSVD_FIRST + 8'(i), 8'h5a);
			u_host.rd(ADDR_RSVD_FIRST + 8'(i), v);
			chk("rsvd", 16'h0, v);
		end
		u_host.rd(ADDR_POL_STATUS, v);
		chk("stat", 16'hc0, v);
		chk("sep", 16'ha5, sep);
	endtask
	task automatic t_div();
		u_host.wr(ADDR_DIV_HIGH, 8'h12);
		repeat (3) @(posedge clk);
		chk("pend", 16'd1694, ratio);
		u_host.wr(ADDR_DIV_LOW, 8'h30);
		#1;
		chk("load", 16'h1, ld);
		chk("ratio", 16'd292, ratio);
		u_host.wr(ADDR_DIV_LOW, 8'h4f);
		#1;
		chk("reload", 16'd293, ratio);
	endtask
	initial begin
		resetn = 1'b0;
		hs_pin = 1'b0;
		co_pin = 1'b0;
		vs_pin = 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		u_host.init();
		t_regs();
		t_pol();
		t_rsvd();
		t_div();
		test_done();
	end
	// Whole run is about 110 cycles
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
endmodule
bind sync_coast_format_control_regs sync_coast_regs_chk u_chk (.clk, .resetn, .wr_en, .wr_addr, .wr_data,
	.rd_addr, .rd_data, .sep_threshold, .scan_enable, .slicer_threshold, .coast_lead_count,
	.coast_trail_count, .format_444, .pixel_divide_ratio, .pixel_divider_load);
